// ===== verilog/pfc_pkg.sv
// Purpose: Shared constants for the protection feature configuration block.
// Assumes: 100 MHz clock; register offsets as byte addresses on the port.
// Notes:   Delay counts derive from times in microseconds.
package pfc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_DISCHARGE_SET = 8'h05;
    localparam logic [7:0] ADDR_CHARGE_TIME   = 8'h06;
    localparam logic [7:0] ADDR_FEATURE_SET   = 8'h07;
    localparam logic [7:0] ADDR_WRITE_ENABLE  = 8'h08;
    localparam logic [7:0] RESET_VALUE        = 8'h00;

    // ==========================================================
    // Field positions
    localparam int CT_AUTO_OFF_DIS = 7;
    localparam int CT_THR_HI       = 6;
    localparam int CT_THR_LO       = 5;
    localparam int CT_SC_LONG      = 4;
    localparam int CT_CHG_DIV      = 3;
    localparam int CT_DIS_DIV      = 2;
    localparam int CT_TO_HI        = 1;
    localparam int CT_TO_LO        = 0;
    localparam int FS_SCAN_OFF     = 7;
    localparam int FS_REG_DIS      = 6;
    localparam int FS_TEMP_ON      = 5;
    localparam int FS_XOT_DIS      = 4;
    localparam int FS_IOT_DIS      = 3;
    localparam int FS_FORCE_POR    = 2;
    localparam int FS_WAKE_DIS     = 1;
    localparam int FS_WAKE_POL     = 0;
    localparam int WE_FEATURE      = 7;
    localparam int WE_CHARGE       = 6;

    // ==========================================================
    // Times
    localparam int CLK_MHZ       = 100;
    localparam int TICK_US       = 100;
    localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
    localparam int SC_SHORT_US   = 100;
    localparam int SC_LONG_US    = 10000;
    localparam int SCAN_ON_US    = 5000;
    localparam int SCAN_PERIOD_US = 640000;
    // Charge time-outs in 100 us ticks: 80/160/320/640 ms.
    localparam logic [12:0] OCC_TICKS_0 = 13'd800;
    localparam logic [12:0] OCC_TICKS_1 = 13'd1600;
    localparam logic [12:0] OCC_TICKS_2 = 13'd3200;
    localparam logic [12:0] OCC_TICKS_3 = 13'd6400;
    // Divided charge time-outs in ticks: 2.5/4/8/16 ms.
    localparam logic [12:0] OCC_DIV_0 = 13'd25;
    localparam logic [12:0] OCC_DIV_1 = 13'd40;
    localparam logic [12:0] OCC_DIV_2 = 13'd80;
    localparam logic [12:0] OCC_DIV_3 = 13'd160;
    localparam logic [12:0] SC_SHORT_TICKS =
        13'(SC_SHORT_US / TICK_US);
    localparam logic [12:0] SC_LONG_TICKS = 13'(SC_LONG_US / TICK_US);
    localparam logic [12:0] SCAN_ON_TICKS = 13'(SCAN_ON_US / TICK_US);
    localparam logic [12:0] SCAN_PERIOD_TICKS =
        13'(SCAN_PERIOD_US / TICK_US);
    localparam logic [6:0] DIS_DIV_FACTOR = 7'd64;

    // ==========================================================
    // Threshold codes (0.10/0.12/0.14/0.16 V).
    typedef enum logic [1:0] {
        PFC_THR_100MV = 2'b00,
        PFC_THR_120MV = 2'b01,
        PFC_THR_140MV = 2'b10,
        PFC_THR_160MV = 2'b11
    } pfc_thr_t;

endpackage : pfc_pkg

// ===== verilog/pfc_core.sv
// Purpose: Charge/time-scale and feature-set registers with protection logic.
// Assumes: Register port from the serial interface, one write pulse per byte.
// Notes:   Comparator inputs are asynchronous and are synchronised here.
//
// Contract
// R1: Charge overcurrent switches FETs off unless auto-off is disabled.
// R2: Charge overcurrent always sets its flag, which powers the sensor supply.
// R3: Bits 6:5 select charge threshold 0.10, 0.12, 0.14 or 0.16 V.
// R4: Short circuit must last 100 us, or 10 ms with long delay.
// R5: Charge delay divide bit shortens the charge delay by 32; the code divides 80 ms by 32 and 160-640 ms by 40.
// R6: Discharge delay divide bit shortens the discharge delay by 64.
// R7: Bits 1:0 select 80-640 ms, or 2.5-16 ms when divided.
// R8: Unless scan is off, power temperature sensing 5 ms per 640 ms.
// R9: Regulator disable bit turns the internal regulator off.
// R10: Keep-on bit holds the sensor supply on continuously.
// R11: External over-temperature shutdown can be disabled; software decides.
// R12: Internal over-temperature shutdown can be disabled; software decides.
// R13: Force reset bit clears every register including itself.
// R14: Wake disable blocks wake pin; only a write or power cycle revives.
// R15: Wake on rising edge when polarity is one, falling when zero.
// R16: Software keeps polarity zero on the cascaded upper device.
// R17: Trip only when sense exceeds threshold longer than the delay.
// R18: Charge register writes need the charge write enable, zero at reset.
// R19: Feature register writes need the feature write enable, zero at reset.
// R20: Condition clearing early restarts the timer with no trip.
`timescale 1ns/100ps

module pfc_core
    import pfc_pkg::*;
(
    input  wire logic       clock,            // System clock.
    input  wire logic       rstn,             // Synchronous reset, low.
    input  wire logic       clk_en,           // Clock enable; low freezes.
    input  wire logic [7:0] reg_addr,         // Register address.
    input  wire logic [7:0] reg_wdata,        // Write data.
    input  wire logic       reg_write,        // Write strobe, one cycle.
    output logic      [7:0] reg_rdata,        // Read data, registered.
    input  wire logic       occ_above,        // Charge sense above threshold.
    input  wire logic       sc_above,         // Short circuit sense above.
    input  wire logic       ext_ot,           // External over-temperature.
    input  wire logic       int_ot,           // Internal over-temperature.
    input  wire logic       wake_pin,         // Wake pin level.
    input  wire logic       asleep,           // Device is in sleep state.
    input  wire logic       charge_oc_clear,  // Software clears the flag.
    output logic      [1:0] charge_oc_threshold_sel, // Comparator select.
    output logic            discharge_delay_div, // Discharge delay by 64.
    output logic            charge_oc_flag,   // Charge overcurrent flag.
    output logic            sc_trip,          // Short circuit trip.
    output logic            ext_overtemp_flag, // External over-temp flag.
    output logic            int_overtemp_flag, // Internal over-temp flag.
    output logic            fet_off,          // Force power FETs off.
    output logic            balance_off,      // Force balance FETs off.
    output logic            temp_sensor_supply, // Sensor supply on.
    output logic            int_regulator_disable, // Regulator off.
    output logic            wake_event        // Wake request pulse.
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  charge_time_scale_config;
        logic [7:0]  feature_set_config;
        logic [7:0]  write_enable;
        logic [7:0]  rdata;
        logic [2:0]  occ_sync;
        logic        occ_s;
        logic [2:0]  sc_sync;
        logic        sc_s;
        logic [2:0]  xot_sync;
        logic        xot_s;
        logic [2:0]  iot_sync;
        logic        iot_s;
        logic [2:0]  wake_sync;
        logic        wake_s;
        logic [13:0] prescale;
        logic [12:0] occ_cnt;
        logic [12:0] sc_cnt;
        logic [12:0] scan_cnt;
        logic        occ_flag;
        logic        sc_flag;
        logic        wake;
    } pfc_state_t;

    pfc_state_t r;
    pfc_state_t next_r;

    // Filters a synchronised level: the stable value moves once the
    // second and third stages agree.
    function automatic logic filt(input logic [2:0] s, input logic q);
        filt = (s[1] == s[2]) ? s[2] : q;
    endfunction : filt

    // Charge time-out in 100 us ticks.
    function automatic logic [12:0] occ_limit(input logic [7:0] c);
        logic [1:0] sel;
        sel = {c[CT_TO_HI], c[CT_TO_LO]};
        if (c[CT_CHG_DIV]) begin // R5
            unique case (sel) // R7
                2'b00: occ_limit = OCC_DIV_0;
                2'b01: occ_limit = OCC_DIV_1;
                2'b10: occ_limit = OCC_DIV_2;
                2'b11: occ_limit = OCC_DIV_3;
            endcase
        end else begin
            unique case (sel) // R7
                2'b00: occ_limit = OCC_TICKS_0;
                2'b01: occ_limit = OCC_TICKS_1;
                2'b10: occ_limit = OCC_TICKS_2;
                2'b11: occ_limit = OCC_TICKS_3;
            endcase
        end
    endfunction : occ_limit

    logic        tick;
    logic [12:0] sc_limit;
    logic        scan_on;

    // ==========================================================
    // Next state
    always_comb begin
        next_r = r;
        tick = (r.prescale == 14'(TICK_CYCLES - 1));
        sc_limit = r.charge_time_scale_config[CT_SC_LONG] ?
            SC_LONG_TICKS : SC_SHORT_TICKS; // R4
        scan_on = r.scan_cnt < SCAN_ON_TICKS;

        next_r.occ_sync  = {r.occ_sync[1:0], occ_above};
        next_r.sc_sync   = {r.sc_sync[1:0], sc_above};
        next_r.xot_sync  = {r.xot_sync[1:0], ext_ot};
        next_r.iot_sync  = {r.iot_sync[1:0], int_ot};
        // The wake pin is held inverted so that its idle high level
        // matches the cleared value and no false edge follows reset.
        next_r.wake_sync = {r.wake_sync[1:0], ~wake_pin};
        next_r.occ_s  = filt(r.occ_sync, r.occ_s);
        next_r.sc_s   = filt(r.sc_sync, r.sc_s);
        next_r.xot_s  = filt(r.xot_sync, r.xot_s);
        next_r.iot_s  = filt(r.iot_sync, r.iot_s);
        next_r.wake_s = filt(r.wake_sync, r.wake_s);

        next_r.prescale = tick ? 14'd0 : r.prescale + 14'd1;

        if (!r.occ_s) begin
            next_r.occ_cnt = 13'd0; // R20
        end else if (tick && r.occ_cnt <= occ_limit(
                r.charge_time_scale_config)) begin // R17
            next_r.occ_cnt = r.occ_cnt + 13'd1;
        end
        if (!r.sc_s) begin
            next_r.sc_cnt = 13'd0; // R20
        end else if (tick && r.sc_cnt <= sc_limit) begin // R17
            next_r.sc_cnt = r.sc_cnt + 13'd1;
        end

        if (charge_oc_clear) begin
            next_r.occ_flag = 1'b0;
        end
        // Ticks run free, so one extra full tick guarantees the sense
        // has been high for at least the whole selected delay.
        if (r.occ_s && r.occ_cnt > occ_limit(
                r.charge_time_scale_config)) begin
            next_r.occ_flag = 1'b1; // R17 R2
        end
        next_r.sc_flag = r.sc_s && r.sc_cnt > sc_limit; // R17 R4

        if (tick) begin
            next_r.scan_cnt = (r.scan_cnt == SCAN_PERIOD_TICKS - 13'd1) ?
                13'd0 : r.scan_cnt + 13'd1; // R8
        end

        next_r.wake = 1'b0;
        if (asleep && !r.feature_set_config[FS_WAKE_DIS]) begin // R14
            next_r.wake = r.feature_set_config[FS_WAKE_POL] ?
                (r.wake_s && !next_r.wake_s) :
                (!r.wake_s && next_r.wake_s); // R15
        end

        if (reg_write) begin
            unique case (reg_addr)
                ADDR_CHARGE_TIME: begin
                    if (r.write_enable[WE_CHARGE]) begin // R18
                        next_r.charge_time_scale_config = reg_wdata;
                    end
                end
                ADDR_FEATURE_SET: begin
                    if (r.write_enable[WE_FEATURE]) begin // R19
                        next_r.feature_set_config = reg_wdata;
                    end
                end
                ADDR_WRITE_ENABLE: next_r.write_enable = reg_wdata;
                default: ;
            endcase
        end

        unique case (reg_addr)
            ADDR_CHARGE_TIME:  next_r.rdata = r.charge_time_scale_config;
            ADDR_FEATURE_SET:  next_r.rdata = r.feature_set_config;
            ADDR_WRITE_ENABLE: next_r.rdata = r.write_enable;
            default:           next_r.rdata = RESET_VALUE;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock) begin
        if (!rstn || r.feature_set_config[FS_FORCE_POR]) begin // R13
            r <= '0;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        reg_rdata = r.rdata;
        charge_oc_threshold_sel = {r.charge_time_scale_config[CT_THR_HI],
            r.charge_time_scale_config[CT_THR_LO]}; // R3
        discharge_delay_div = r.charge_time_scale_config[CT_DIS_DIV]; // R6
        charge_oc_flag = r.occ_flag;
        sc_trip = r.sc_flag;
        ext_overtemp_flag = r.xot_s;
        int_overtemp_flag = r.iot_s;
        balance_off = (r.xot_s && !r.feature_set_config[FS_XOT_DIS]) // R11
            || (r.iot_s && !r.feature_set_config[FS_IOT_DIS]); // R12
        fet_off = balance_off || r.sc_flag || (r.occ_flag && // R4
            !r.charge_time_scale_config[CT_AUTO_OFF_DIS]); // R1
        temp_sensor_supply = r.occ_flag // R2
            || r.feature_set_config[FS_TEMP_ON] // R10
            || (scan_on && !r.feature_set_config[FS_SCAN_OFF]); // R8
        int_regulator_disable = r.feature_set_config[FS_REG_DIS]; // R9
        wake_event = r.wake;
    end

endmodule : pfc_core

// ===== bench/pfc_checker.sv
// Purpose: Port assertions for the feature configuration block.
// Assumes: Bound to pfc_core.
// Notes:   Register fields are seen only through the read data.
`timescale 1ns/100ps
module pfc_checker
    import pfc_pkg::*;
(
    input wire logic       clock,                   // Clock.
    input wire logic       rstn,                    // Reset, low.
    input wire logic       clk_en,                  // Enable.
    input wire logic [7:0] reg_addr,                // Address.
    input wire logic       reg_write,               // Write.
    input wire logic [7:0] reg_rdata,               // Read data.
    input wire logic       sc_above,                // Short sense.
    input wire logic       asleep,                  // Asleep.
    input wire logic [1:0] charge_oc_threshold_sel, // Threshold.
    input wire logic       discharge_delay_div,     // Divide.
    input wire logic       charge_oc_flag,          // Flag.
    input wire logic       sc_trip,                 // Trip.
    input wire logic       fet_off,                 // FETs off.
    input wire logic       temp_sensor_supply,      // Supply.
    input wire logic       int_regulator_disable,   // Regulator.
    input wire logic       wake_event               // Wake.
);
    logic [1:0] wr_hist;
    logic [7:0] addr_q;
    logic       quiet;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Read data equals a register that no recent write has touched.
    always_ff @(posedge clock) begin
        wr_hist <= {wr_hist[0], reg_write | !clk_en};
        addr_q  <= reg_addr;
    end
    assign quiet = wr_hist == 2'b00 && addr_q == reg_addr;
    property p_thr;
        quiet && reg_addr == ADDR_CHARGE_TIME
            |-> charge_oc_threshold_sel == reg_rdata[6:5];
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold select differs from register");
    property p_div;
        quiet && reg_addr == ADDR_CHARGE_TIME
            |-> discharge_delay_div == reg_rdata[2];
    endproperty
    a_div: assert property (p_div)
        else $error("discharge divide differs from register");
    property p_reg_dis;
        quiet && reg_addr == ADDR_FEATURE_SET
            |-> int_regulator_disable == reg_rdata[6];
    endproperty
    a_reg_dis: assert property (p_reg_dis)
        else $error("regulator disable differs from register");
    property p_unmapped;
        clk_en && !(reg_addr inside {8'h06, 8'h07, 8'h08})
            |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read nonzero");
    property p_sc_fet;
        sc_trip |-> fet_off;
    endproperty
    a_sc_fet: assert property (p_sc_fet)
        else $error("short trip without FET shutdown");
    property p_sc_release;
        (clk_en && !sc_above) [*8] |=> !sc_trip;
    endproperty
    a_sc_release: assert property (p_sc_release)
        else $error("short trip held after sense cleared");
    property p_flag_supply;
        charge_oc_flag [*2] |-> temp_sensor_supply;
    endproperty
    a_flag_supply: assert property (p_flag_supply)
        else $error("flag set but sensor supply off");
    property p_wake_pulse;
        wake_event |=> !wake_event;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse longer than one cycle");
    property p_wake_sleep;
        wake_event |-> $past(asleep) || $past(asleep, 2);
    endproperty
    a_wake_sleep: assert property (p_wake_sleep)
        else $error("wake pulse while awake");
endmodule : pfc_checker
bind pfc_core pfc_checker pfc_checker_inst (
    .clock, .rstn, .clk_en, .reg_addr, .reg_write, .reg_rdata, .sc_above,
    .asleep, .charge_oc_threshold_sel, .discharge_delay_div,
    .charge_oc_flag, .sc_trip, .fet_off, .temp_sensor_supply,
    .int_regulator_disable, .wake_event);

// ===== bench/pfc_mcu_model.sv
// Purpose: Microcontroller model on the register write port.
// Assumes: Single byte accesses, one at a time.
// Notes:   Released write data is inverted so stale data never passes.
`timescale 1ns/100ps
module pfc_mcu_model (
    input  wire logic       clock,     // System clock.
    output logic      [7:0] reg_addr,  // Address.
    output logic      [7:0] reg_wdata, // Write data.
    output logic            reg_write, // Write strobe.
    input  wire logic [7:0] reg_rdata  // Read data.
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 v = reg_rdata;
    endtask : rd
endmodule : pfc_mcu_model

// ===== bench/tb.sv
// Purpose: Self-checking bench for the feature configuration registers.
// Assumes: Fixed 100 us tick inside the design.
// Notes:   Charge time-outs are too long to run here.
`timescale 1ns/100ps
module tb;
    import pfc_pkg::*;
    logic       clock    = 1'b0;
    logic       rstn     = 1'b0;
    logic       sc_above = 1'b0;
    logic       wake_pin = 1'b1;
    logic       asleep   = 1'b0;
    logic [1:0] ot       = 2'b00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, cfg;
    logic [1:0] thr;
    logic       reg_write, dd, flag, trip, xf, itf, fet, bal, sup, rdis;
    logic       wev, seen_w, seen_t;
    int         num_errors = 0;
    int         num_checks = 0;
    pfc_mcu_model pfc_mcu_model_inst (.clock, .reg_addr, .reg_wdata,
        .reg_write, .reg_rdata);
    pfc_core pfc_core_inst (.clock, .rstn, .clk_en(1'b1), .reg_addr,
        .reg_wdata, .reg_write, .reg_rdata, .occ_above(1'b0), .sc_above,
        .ext_ot(ot[1]), .int_ot(ot[0]), .wake_pin, .asleep,
        .charge_oc_clear(1'b0), .charge_oc_threshold_sel(thr),
        .discharge_delay_div(dd), .charge_oc_flag(flag), .sc_trip(trip),
        .ext_overtemp_flag(xf), .int_overtemp_flag(itf), .fet_off(fet),
        .balance_off(bal), .temp_sensor_supply(sup),
        .int_regulator_disable(rdis), .wake_event(wev));
    always #5 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        pfc_mcu_model_inst.wr(a, v);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        pfc_mcu_model_inst.rd(a, d);
        chk(d, exp);
    endtask : rdchk
    task automatic watch(input int c);
        seen_w = 1'b0;
        seen_t = 1'b0;
        repeat (c) begin
            @(posedge clock);
            #1 seen_w |= wev;
            seen_t |= trip;
        end
    endtask : watch
    task final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        rdchk(ADDR_WRITE_ENABLE, 8'h00);
        chk(sup, 1'b1);
        wr(ADDR_CHARGE_TIME, 8'hff);
        wr(ADDR_FEATURE_SET, 8'h60);
        rdchk(ADDR_CHARGE_TIME, 8'h00);
        rdchk(ADDR_FEATURE_SET, 8'h00);
        wr(ADDR_WRITE_ENABLE, 8'hc0);
        wr(8'h05, 8'hff);
        rdchk(8'h05, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CHARGE_TIME, {1'b0, i[1:0], 5'h04});
            rdchk(ADDR_CHARGE_TIME, {1'b0, i[1:0], 5'h04});
            chk(thr, i[1:0]);
            chk(dd, 1'b1);
        end
        // Regulator off assumes an external supply on the output.
        wr(ADDR_FEATURE_SET, 8'h60);
        rdchk(ADDR_FEATURE_SET, 8'h60);
        chk({rdis, sup}, 2'b11);
        wr(ADDR_FEATURE_SET, 8'h80);
        rdchk(ADDR_FEATURE_SET, 8'h80);
        chk({rdis, sup}, 2'b00);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            ot <= 2'b10 >> k;
            repeat (10) @(posedge clock);
            chk({fet, bal}, 2'b11);
            wr(ADDR_FEATURE_SET, 8'h80 | (8'h10 >> k));
            rdchk(ADDR_FEATURE_SET, 8'h80 | (8'h10 >> k));
            chk({fet, bal, xf, itf}, 2'b10 >> k);
            ot <= 2'b00;
        end
        asleep <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            cfg = (k == 0) ? 8'h81 : (k == 1) ? 8'h80 : 8'h82;
            wr(ADDR_FEATURE_SET, cfg);
            wake_pin <= ~cfg[0];
            watch(10);
            wake_pin <= cfg[0];
            watch(12);
            chk(seen_w, k != 2);
        end
        asleep <= 1'b0;
        sc_above <= 1'b1;
        watch(9000);
        sc_above <= 1'b0;
        chk(seen_t, 1'b0);
        watch(20);
        sc_above <= 1'b1;
        watch(9000);
        chk(seen_t, 1'b0);
        for (int n = 0; n < 12000 && trip !== 1'b1; n++) watch(1);
        chk({trip, fet}, 2'b11);
        sc_above <= 1'b0;
        watch(12);
        chk(trip, 1'b0);
        wr(ADDR_FEATURE_SET, 8'h04);
        rdchk(ADDR_WRITE_ENABLE, 8'h00);
        rdchk(ADDR_CHARGE_TIME, 8'h00);
        wr(ADDR_CHARGE_TIME, 8'hff);
        rdchk(ADDR_CHARGE_TIME, 8'h00);
        final_report();
    end
endmodule : tb
